// File: fpe_chk.sv
// Checker on the program port wires joining both ends.
// Assumes srst is high while either end is held in reset.
`timescale 1ns/1ps
module fpe_chk
   import fpe_pkg::*;
#(
   parameter int unsigned ENTRY_WAIT = ENTRY_WAIT_CYC
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic program_request_n,
   input wire logic port_select_n,
   input wire logic programmer_serial_clock,
   input wire logic device_to_programmer_oe,
   input wire logic serial_to_device_line,
   input wire logic serial_to_programmer_line
);
   logic [7:0]  hi_r;
   logic [7:0]  lo_r;
   logic [31:0] age_r;
   logic        seen_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // Gap counters saturate so a long idle stretch cannot wrap to zero.
   always_ff @(posedge mclk) begin
      if (srst) begin
         hi_r <= 8'hFF;
         lo_r <= 8'h00;
         age_r <= 32'h0;
         seen_r <= 1'h0;
      end else begin
         hi_r <= port_select_n ? hi_r + {7'h0, hi_r != 8'hFF} : 8'h00;
         lo_r <= programmer_serial_clock ? 8'h00
                                         : lo_r + {7'h0, lo_r != 8'hFF};
         age_r <= age_r + 32'h1;
         seen_r <= seen_r | !port_select_n | !serial_to_device_line;
      end
   end
   // Properties over the link wires.
   property p_sck_still; port_select_n |-> !programmer_serial_clock;
   endproperty
   a_sck_still: assert property (p_sck_still)
      else $error("serial clock moved outside a frame");
   property p_sck_high; $rose(programmer_serial_clock)
      |-> programmer_serial_clock [*7]; endproperty
   a_sck_high: assert property (p_sck_high)
      else $error("serial clock high phase too short");
   property p_sck_low; $fell(programmer_serial_clock)
      |-> !programmer_serial_clock [*7]; endproperty
   a_sck_low: assert property (p_sck_low)
      else $error("serial clock low phase too short");
   property p_oe_off; port_select_n && $past(port_select_n)
      |-> !device_to_programmer_oe; endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("device drives data line while unselected");
   property p_oe_on; $fell(programmer_serial_clock) && !port_select_n
      |-> device_to_programmer_oe; endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("device not driving data line in a frame");
   property p_ss_gap; $fell(port_select_n) |-> hi_r >= SS_HIGH_CYC;
   endproperty
   a_ss_gap: assert property (p_ss_gap)
      else $error("select high time too short");
   property p_last; $rose(port_select_n) |-> lo_r >= LAST_SCLK_CYC;
   endproperty
   a_last: assert property (p_last)
      else $error("select rose too soon after last clock");
   property p_req; $rose(program_request_n) |-> seen_r; endproperty
   a_req: assert property (p_req)
      else $error("request released before first access");
   property p_entry; !seen_r && (!port_select_n || !serial_to_device_line)
      |-> age_r >= ENTRY_WAIT; endproperty
   a_entry: assert property (p_entry)
      else $error("first access too early after reset");
   property p_start; $fell(serial_to_programmer_line)
      |-> !serial_to_programmer_line [*8]; endproperty
   a_start: assert property (p_start)
      else $error("device start bit too short");
endmodule

// File: fpe_dev.sv
// Device end of the program port: decides at reset release between
// programming and application mode, and receives programmer bytes over an
// SPI slave port or a serial port into a two-entry buffer.
// Assumes a 50 MHz mclk, a synchronous active-high reset, and a programmer
// clock that only toggles while the port select is low.
`timescale 1ns/1ps
module fpe_dev
   import fpe_pkg::*;
#(
   parameter int unsigned TIMEOUT = CMD_TIMEOUT_CYC
) (
   input  wire logic        mclk,
   input  wire logic        srst,
   fpe_if.dev               lnk,
   output logic [7:0]       rx_data,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [15:0] baud_div,
   input  wire logic        baud_load,
   output logic             prog_mode,
   output logic             app_mode,
   output logic             overrun
);

   // The timer width bounds the timeout that can be served.
   if (TIMEOUT < 1 || TIMEOUT > (1 << TIMER_W)) begin : g_bad_timeout
      $error("TIMEOUT out of range");
   end

   localparam logic [TIMER_W-1:0] TIMEOUT_LAST = TIMER_W'(TIMEOUT - 1);

   fpe_dev_s   q;
   fpe_dev_s   d;
   fpe_spi_s   spi_q;
   fpe_spi_s   spi_d;
   logic [1:0] room_sync = 2'h0;
   logic [1:0] prog_sync = 2'h0;
   logic [7:0] reply;
   logic       spi_new;
   logic       cmd_seen;
   logic       in_prog;

   // Places one byte in the buffer; a full buffer drops it and flags it.
   function automatic fpe_dev_s push_byte(fpe_dev_s s, logic [7:0] b);
      fpe_dev_s n;
      n = s;
      if (!s.rx_valid) begin
         n.rx_valid = 1'h1;
         n.rx_data  = b;
      end else if (!s.v1) begin
         n.v1 = 1'h1;
         n.d1 = b;
      end else begin
         n.overrun = 1'h1;
      end
      return n;
   endfunction

   // Link side, on the programmer's clock. The status levels cross in with
   // two flops; they need no reset since the clock only runs in frames.
   always_ff @(posedge lnk.programmer_serial_clock) begin
      room_sync <= {room_sync[0], q.room};
      prog_sync <= {prog_sync[0], q.prog};
   end

   // Shift logic for one SPI frame. Bits go most significant first; the
   // device samples its input on the rising edge and moves its output
   // after it, so the programmer samples on the falling edge.
   always_comb begin
      reply                 = 8'h00;
      reply[REPLY_ROOM_BIT] = room_sync[1];
      reply[REPLY_PROG_BIT] = prog_sync[1];
      spi_d                 = spi_q;
      spi_d.oe              = 1'h1;
      spi_d.cnt             = spi_q.cnt + 3'h1;
      spi_d.sh_rx = {spi_q.sh_rx[6:0], lnk.programmer_to_device_line};
      if (spi_q.cnt == 3'h0) begin
         // A new byte starts; the previous one has long been taken.
         spi_d.flag  = 1'h0;
         spi_d.miso  = reply[7];
         spi_d.tx_sh = {reply[6:0], 1'h0};
      end else begin
         spi_d.miso  = spi_q.tx_sh[7];
         spi_d.tx_sh = {spi_q.tx_sh[6:0], 1'h0};
      end
      if (spi_q.cnt == 3'h7) begin
         spi_d.rx_byte = {spi_q.sh_rx[6:0], lnk.programmer_to_device_line};
         spi_d.flag    = 1'h1;
      end
   end

   // The frame's own select clears the link side, so a cut-short frame
   // cannot leave the bit count out of step and the output is released
   // as soon as select rises. The clock may be stopped at that moment.
   always_ff @(posedge lnk.programmer_serial_clock
               or posedge lnk.port_select_n) begin
      if (lnk.port_select_n) begin
         spi_q <= SPI_RST;
      end else begin
         spi_q <= spi_d;
      end
   end

   // System side next state.
   always_comb begin
      d          = q;
      d.req_s1   = lnk.program_request_n;
      d.req_s2   = q.req_s1;
      d.rx_s1    = lnk.serial_to_device_line;
      d.rx_s2    = q.rx_s1;
      // The byte flag crosses as a level through two flops; its rise marks
      // a byte. The byte register itself holds still for at least one
      // serial clock period after that, far longer than the crossing.
      d.spi_f1   = spi_q.flag;
      d.spi_f2   = q.spi_f1;
      d.spi_f3   = q.spi_f2;
      spi_new    = q.spi_f2 && !q.spi_f3;
      in_prog    = (q.st == M_WAIT) || (q.st == M_ACTIVE);

      // A rate change is taken from the protocol engine at any time.
      if (baud_load) begin
         d.baud = baud_div;
      end

      // Buffer pop frees room before this cycle's pushes are placed.
      if (q.rx_valid && rx_ready) begin
         d.rx_valid = q.v1;
         d.rx_data  = q.d1;
         d.v1       = 1'h0;
      end

      // Serial receiver and transmitter run at the current rate.
      d.urx    = fpe_urx_step(q.urx, q.rx_s2, q.baud);
      cmd_seen = spi_new || d.urx.done;
      if (in_prog && spi_new) begin
         d = push_byte(d, spi_q.rx_byte);
      end
      if (in_prog && d.urx.done) begin
         d = push_byte(d, d.urx.sh);
      end
      d.utx = fpe_utx_step(q.utx, tx_valid && q.tx_ready, tx_data,
                           q.baud);

      // Mode decision after reset release.
      case (q.st)
         M_SAMPLE: begin
            if (q.req_s2) begin
               d.st = M_APP;
            end else if (q.stable == STABLE_LAST) begin
               d.st = M_WAIT;
            end else begin
               d.stable = q.stable + 5'h01;
            end
         end
         M_WAIT: begin
            if (cmd_seen) begin
               d.st = M_ACTIVE;
            end else if (q.timer == TIMEOUT_LAST) begin
               d.st = M_APP;
            end else begin
               d.timer = q.timer + 1'h1;
            end
         end
         M_ACTIVE: d.st = M_ACTIVE;
         M_APP:    d.st = M_APP;
         default:  d.st = M_APP;
      endcase

      // Registered outputs follow the next state.
      d.prog     = (d.st == M_WAIT) || (d.st == M_ACTIVE);
      d.app      = (d.st == M_APP);
      d.tx_ready = d.prog && !d.utx.busy;
      d.room     = !d.v1;

      // Reset clears all state but keeps the pin synchronisers running,
      // so the request level is already settled when reset is released.
      if (srst) begin
         d        = DEV_RST;
         d.req_s1 = lnk.program_request_n;
         d.req_s2 = q.req_s1;
         d.rx_s1  = lnk.serial_to_device_line;
         d.rx_s2  = q.rx_s1;
      end
   end

   // All system side state registers here.
   always_ff @(posedge mclk) begin
      q <= d;
   end

   // Outputs, each straight from a flop.
   assign lnk.device_to_programmer_line = spi_q.miso;
   assign lnk.device_to_programmer_oe   = spi_q.oe;
   assign lnk.serial_to_programmer_line = q.utx.line;
   assign rx_data                       = q.rx_data;
   assign rx_valid                      = q.rx_valid;
   assign tx_ready                      = q.tx_ready;
   assign prog_mode                     = q.prog;
   assign app_mode                      = q.app;
   assign overrun                       = q.overrun;

endmodule

// File: fpe_if.sv
// Program port wires between the device end and the programmer end.
// Assumes a pull-up on the device-to-programmer line when nobody drives it.
`timescale 1ns/1ps
interface fpe_if;
   logic program_request_n;
   logic port_select_n;
   logic programmer_serial_clock;
   logic programmer_to_device_line;
   logic device_to_programmer_line;
   logic device_to_programmer_oe;
   logic serial_to_device_line;
   logic serial_to_programmer_line;
   logic miso_level;

   // The shared line idles high while the device leaves it undriven.
   assign miso_level = device_to_programmer_oe ? device_to_programmer_line
                                               : 1'h1;

   modport dev (
      input  program_request_n,
      input  port_select_n,
      input  programmer_serial_clock,
      input  programmer_to_device_line,
      input  serial_to_device_line,
      output device_to_programmer_line,
      output device_to_programmer_oe,
      output serial_to_programmer_line
   );

   modport prg (
      output program_request_n,
      output port_select_n,
      output programmer_serial_clock,
      output programmer_to_device_line,
      output serial_to_device_line,
      input  miso_level,
      input  serial_to_programmer_line
   );
endinterface

// File: fpe_pkg.sv
// Shared constants, state types and serial helpers for the flash program
// port entry logic. Assumes both ends run from a 50 MHz system clock.
package fpe_pkg;

   // Clock rate and printed timing figures in their own units.
   localparam int unsigned MCLK_HZ       = 50_000_000;
   localparam int unsigned ENTRY_WAIT_MS = 50;
   localparam int unsigned CMD_TIMEOUT_S = 4;
   localparam int unsigned SCLK_MAX_HZ   = 4_000_000;
   localparam int unsigned SS_HIGH_NS    = 2000;
   localparam int unsigned LAST_SCLK_NS  = 2000;
   localparam int unsigned BAUD_DEFAULT  = 57600;
   localparam int unsigned STABLE_CYC    = 16;

   // Derived cycle counts; least times round up, longest round down.
   localparam int unsigned ENTRY_WAIT_CYC  = ENTRY_WAIT_MS * (MCLK_HZ / 1000);
   localparam int unsigned CMD_TIMEOUT_CYC = CMD_TIMEOUT_S * MCLK_HZ;
   localparam int unsigned SCLK_HALF_CYC   =
      (MCLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam int unsigned SS_HIGH_CYC     =
      (SS_HIGH_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned LAST_SCLK_CYC   =
      (LAST_SCLK_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;

   // Field widths and positions.
   localparam int unsigned TIMER_W        = 28;
   localparam int unsigned WAIT_W         = 22;
   localparam int unsigned REPLY_ROOM_BIT = 0;
   localparam int unsigned REPLY_PROG_BIT = 1;
   localparam logic [4:0]  STABLE_LAST    = 5'(STABLE_CYC - 1);
   localparam logic [3:0]  UART_STOP_IDX  = 4'h9;
   localparam logic [15:0] BAUD_DIV_RST   = 16'(MCLK_HZ / BAUD_DEFAULT);

   typedef enum logic [1:0] {M_SAMPLE, M_WAIT, M_ACTIVE, M_APP} fpe_mode_e;
   typedef enum logic [2:0] {P_ENTRY, P_IDLE, P_CLK, P_LAST, P_GAP,
                             P_UART} fpe_pstate_e;

   typedef struct packed {
      logic        busy;
      logic [15:0] div;
      logic [3:0]  idx;
      logic [7:0]  sh;
      logic        done;
   } fpe_urx_s;

   typedef struct packed {
      logic        busy;
      logic [15:0] div;
      logic [3:0]  idx;
      logic [8:0]  sh;
      logic        line;
   } fpe_utx_s;

   // Device end state on the system clock.
   typedef struct packed {
      fpe_mode_e          st;
      logic [TIMER_W-1:0] timer;
      logic [4:0]         stable;
      logic               req_s1, req_s2, rx_s1, rx_s2;
      logic               spi_f1, spi_f2, spi_f3;
      logic               rx_valid, v1, overrun, room;
      logic [7:0]         rx_data, d1;
      logic [15:0]        baud;
      fpe_urx_s           urx;
      fpe_utx_s           utx;
      logic               tx_ready, prog, app;
   } fpe_dev_s;

   // Device end state on the programmer's serial clock.
   typedef struct packed {
      logic [2:0] cnt;
      logic [7:0] sh_rx, rx_byte, tx_sh;
      logic       flag, miso, oe;
   } fpe_spi_s;

   // Programmer end state.
   typedef struct packed {
      fpe_pstate_e       st;
      logic [WAIT_W-1:0] cnt;
      logic [3:0]        bits;
      logic              sclk, ss_n, mosi, req_n;
      logic [7:0]        sh, rsh;
      logic              mi1, mi2, rx1, rx2;
      logic [15:0]       baud;
      fpe_urx_s          urx;
      fpe_utx_s          utx;
      logic              tx_ready, rx_valid;
      logic [7:0]        rx_data;
   } fpe_prg_s;

   localparam fpe_urx_s URX_RST = '{busy: 1'h0, div: 16'h0000, idx: 4'h0,
                                   sh: 8'h00, done: 1'h0};
   localparam fpe_utx_s UTX_RST = '{busy: 1'h0, div: 16'h0000, idx: 4'h0,
                                   sh: 9'h1FF, line: 1'h1};
   localparam fpe_spi_s SPI_RST = '0;
   localparam fpe_dev_s DEV_RST = '{st: M_SAMPLE, timer: '0, stable: 5'h00,
      req_s1: 1'h1, req_s2: 1'h1, rx_s1: 1'h1, rx_s2: 1'h1, spi_f1: 1'h0,
      spi_f2: 1'h0, spi_f3: 1'h0, rx_valid: 1'h0, v1: 1'h0, overrun: 1'h0,
      room: 1'h1, rx_data: 8'h00, d1: 8'h00, baud: BAUD_DIV_RST,
      urx: URX_RST, utx: UTX_RST, tx_ready: 1'h0, prog: 1'h0, app: 1'h0};
   localparam fpe_prg_s PRG_RST = '{st: P_ENTRY, cnt: '0, bits: 4'h0,
      sclk: 1'h0, ss_n: 1'h1, mosi: 1'h0, req_n: 1'h0, sh: 8'h00,
      rsh: 8'h00, mi1: 1'h1, mi2: 1'h1, rx1: 1'h1, rx2: 1'h1,
      baud: BAUD_DIV_RST, urx: URX_RST, utx: UTX_RST, tx_ready: 1'h0,
      rx_valid: 1'h0, rx_data: 8'h00};

   // One clock of an 8N1 receiver; samples each bit at its middle.
   function automatic fpe_urx_s fpe_urx_step(fpe_urx_s s, logic line,
                                             logic [15:0] baud);
      fpe_urx_s n;
      n = s;
      n.done = 1'h0;
      if (!s.busy) begin
         if (!line) begin
            n.busy = 1'h1;
            n.div  = baud >> 1;
            n.idx  = 4'h0;
         end
      end else if (s.div != 16'h0000) begin
         n.div = s.div - 16'h0001;
      end else begin
         n.div = baud - 16'h0001;
         n.idx = s.idx + 4'h1;
         if (s.idx == 4'h0 && line) begin
            n.busy = 1'h0; // Glitch, not a start bit.
         end else if (s.idx == UART_STOP_IDX) begin
            n.busy = 1'h0;
            n.done = line; // A low stop bit drops the character.
         end else if (s.idx != 4'h0) begin
            n.sh = {line, s.sh[7:1]};
         end
      end
      return n;
   endfunction

   // One clock of an 8N1 transmitter, least significant bit first.
   function automatic fpe_utx_s fpe_utx_step(fpe_utx_s s, logic go,
                                             logic [7:0] d,
                                             logic [15:0] baud);
      fpe_utx_s n;
      n = s;
      if (!s.busy) begin
         if (go) begin
            n.busy = 1'h1;
            n.sh   = {1'h1, d};
            n.line = 1'h0;
            n.idx  = 4'h0;
            n.div  = baud - 16'h0001;
         end
      end else if (s.div != 16'h0000) begin
         n.div = s.div - 16'h0001;
      end else if (s.idx == UART_STOP_IDX) begin
         n.busy = 1'h0;
      end else begin
         n.div  = baud - 16'h0001;
         n.line = s.sh[0];
         n.sh   = {1'h1, s.sh[8:1]};
         n.idx  = s.idx + 4'h1;
      end
      return n;
   endfunction

endpackage

// File: fpe_prg.sv
// Programmer end: holds the request low, waits out the entry delay, then
// moves bytes over the SPI port or the serial port. Assumes a 50 MHz mclk.
`timescale 1ns/1ps
module fpe_prg
   import fpe_pkg::*;
#(
   parameter int unsigned ENTRY_WAIT = ENTRY_WAIT_CYC,
   parameter int unsigned SCLK_HALF  = SCLK_HALF_CYC
) (
   input  wire logic        mclk,
   input  wire logic        srst,
   fpe_if.prg               lnk,
   input  wire logic        use_serial,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [7:0]       rx_data,
   output logic             rx_valid,
   input  wire logic [15:0] baud_div,
   input  wire logic        baud_load
);

   // A faster clock than the device allows is refused at elaboration.
   if (SCLK_HALF < SCLK_HALF_CYC ||
       SCLK_HALF > (1 << WAIT_W)) begin : g_bad_sclk
      $error("SCLK_HALF out of range");
   end
   if (ENTRY_WAIT < 1 || ENTRY_WAIT > (1 << WAIT_W)) begin : g_bad_wait
      $error("ENTRY_WAIT out of range");
   end

   localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(ENTRY_WAIT - 1);
   localparam logic [WAIT_W-1:0] HALF_LAST = WAIT_W'(SCLK_HALF - 1);
   localparam logic [WAIT_W-1:0] LAST_LAST = WAIT_W'(LAST_SCLK_CYC - 1);
   localparam logic [WAIT_W-1:0] GAP_LAST  = WAIT_W'(SS_HIGH_CYC - 1);

   fpe_prg_s q;
   fpe_prg_s d;
   logic     go_spi;
   logic     go_uart;

   // Next state; pins from the device pass two flops before use.
   always_comb begin
      d          = q;
      d.rx_valid = 1'h0;
      d.mi1      = lnk.miso_level;
      d.mi2      = q.mi1;
      d.rx1      = lnk.serial_to_programmer_line;
      d.rx2      = q.rx1;
      go_spi     = q.tx_ready && tx_valid && !use_serial;
      go_uart    = q.tx_ready && tx_valid && use_serial;
      if (baud_load) begin
         d.baud = baud_div;
      end
      d.urx = fpe_urx_step(q.urx, q.rx2, q.baud);
      d.utx = fpe_utx_step(q.utx, go_uart, tx_data, q.baud);
      if (d.urx.done) begin
         d.rx_valid = 1'h1;
         d.rx_data  = d.urx.sh;
      end
      case (q.st)
         P_ENTRY: begin
            // No access before the entry delay has run out.
            if (q.cnt == WAIT_LAST) begin
               d.st  = P_IDLE;
               d.cnt = '0;
            end else begin
               d.cnt = q.cnt + 1'h1;
            end
         end
         P_IDLE: begin
            if (go_uart) begin
               d.st = P_UART;
            end else if (go_spi) begin
               d.st   = P_CLK;
               d.ss_n = 1'h0;
               d.mosi = tx_data[7];
               d.sh   = {tx_data[6:0], 1'h0};
               d.cnt  = '0;
               d.bits = 4'h0;
            end
         end
         P_CLK: begin
            // Half periods of at least SCLK_HALF cycles.
            if (q.cnt == HALF_LAST) begin
               d.cnt  = '0;
               d.sclk = !q.sclk;
               if (q.sclk) begin
                  d.rsh  = {q.rsh[6:0], q.mi2};
                  d.mosi = q.sh[7];
                  d.sh   = {q.sh[6:0], 1'h0};
                  d.bits = q.bits + 4'h1;
                  if (q.bits == 4'h7) begin
                     d.st = P_LAST;
                  end
               end
            end else begin
               d.cnt = q.cnt + 1'h1;
            end
         end
         P_LAST: begin
            // Select stays low a while after the last clock edge.
            if (q.cnt == LAST_LAST) begin
               d.st       = P_GAP;
               d.cnt      = '0;
               d.ss_n     = 1'h1;
               d.req_n    = 1'h1;
               d.rx_valid = 1'h1;
               d.rx_data  = q.rsh;
            end else begin
               d.cnt = q.cnt + 1'h1;
            end
         end
         P_GAP: begin
            // Least select high time between transactions.
            if (q.cnt == GAP_LAST) begin
               d.st = P_IDLE;
            end else begin
               d.cnt = q.cnt + 1'h1;
            end
         end
         P_UART: begin
            if (!q.utx.busy) begin
               d.st    = P_IDLE;
               d.req_n = 1'h1;
            end
         end
         default: d.st = P_IDLE;
      endcase
      d.tx_ready = (d.st == P_IDLE);
      if (srst) begin
         d = PRG_RST;
      end
   end

   // All state registers on the system clock.
   always_ff @(posedge mclk) begin
      q <= d;
   end

   // Every pin and user output comes straight from a flop.
   assign lnk.program_request_n         = q.req_n;
   assign lnk.port_select_n             = q.ss_n;
   assign lnk.programmer_serial_clock   = q.sclk;
   assign lnk.programmer_to_device_line = q.mosi;
   assign lnk.serial_to_device_line     = q.utx.line;
   assign tx_ready                      = q.tx_ready;
   assign rx_data                       = q.rx_data;
   assign rx_valid                      = q.rx_valid;

endmodule

// File: testbench.sv
// Bench joining both program port ends through the shared link wires.
// Assumes the default serial clock divider and shortened entry counts.
`timescale 1ns/1ps
module testbench;
   import fpe_pkg::*;
   localparam int unsigned TO = 2000;
   logic        mclk = 1'h0, d_rst = 1'h1, p_rst = 1'h1, use_ser = 1'h0;
   logic        p_tv = 1'h0, d_tv = 1'h0, d_rr = 1'h0, bl = 1'h0;
   logic [7:0]  p_td = 8'h00, d_td = 8'h00, p_rd, d_rd, got;
   logic [15:0] bd = 16'h0010;
   logic        p_tr, p_rv, d_tr, d_rv, prog, app, ovr;
   int          error_cnt = 0, tests_run = 0, n0 = 0, pcnt = 0, i;
   fpe_if lnk ();
   fpe_dev #(.TIMEOUT(TO)) fpe_dev_i (.mclk(mclk), .srst(d_rst), .lnk(lnk),
      .rx_data(d_rd), .rx_valid(d_rv), .rx_ready(d_rr), .tx_data(d_td),
      .tx_valid(d_tv), .tx_ready(d_tr), .baud_div(bd), .baud_load(bl),
      .prog_mode(prog), .app_mode(app), .overrun(ovr));
   fpe_prg #(.ENTRY_WAIT(200)) fpe_prg_i (.mclk(mclk), .srst(p_rst),
      .lnk(lnk), .use_serial(use_ser), .tx_data(p_td), .tx_valid(p_tv),
      .tx_ready(p_tr), .rx_data(p_rd), .rx_valid(p_rv), .baud_div(bd),
      .baud_load(bl));
   fpe_chk #(.ENTRY_WAIT(200)) fpe_chk_i (.mclk(mclk),
      .srst(d_rst | p_rst), .program_request_n(lnk.program_request_n),
      .port_select_n(lnk.port_select_n),
      .programmer_serial_clock(lnk.programmer_serial_clock),
      .device_to_programmer_oe(lnk.device_to_programmer_oe),
      .serial_to_device_line(lnk.serial_to_device_line),
      .serial_to_programmer_line(lnk.serial_to_programmer_line));
   // Free-running system clock.
   initial forever #10 mclk = ~mclk;
   // Programmer replies pulse for one cycle only, so latch them here.
   always @(posedge mclk) begin
      if (p_rv === 1'h1) begin
         got <= p_rd;
         pcnt <= pcnt + 1;
      end
   end
   task automatic tally_and_finish();
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return prog;
         2: return d_rv;
         3: return p_tr;
         4: return d_tr;
         5: return pcnt != n0;
         default: return !lnk.serial_to_device_line;
      endcase
   endfunction
   // Waits sample at the falling edge, clear of the launching edge.
   task automatic wt(input int k);
      int j;
      @(negedge mclk);
      for (j = 0; j < 20000 && sig(k) !== 1'h1; j++) @(negedge mclk);
      if (j == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask
   task automatic send(input logic dv, ser, input logic [7:0] d);
      n0 = pcnt;
      wt(dv ? 4 : 3);
      @(posedge mclk);
      use_ser <= ser;
      p_td <= d;
      d_td <= d;
      if (dv) d_tv <= 1'h1;
      else p_tv <= 1'h1;
      @(posedge mclk);
      d_tv <= 1'h0;
      p_tv <= 1'h0;
   endtask
   task automatic pop(input logic [7:0] e);
      wt(2);
      chk("rx_data", d_rd, e);
      @(posedge mclk);
      d_rr <= 1'h1;
      @(posedge mclk);
      d_rr <= 1'h0;
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      d_rst <= 1'h0;
      p_rst <= 1'h0;
      wt(0);
      chk("app_mode", app, 1'h0);
      // Status crosses on the serial clock, so each reply shows the state
      // of the frame before; the very first one shows empty synchronisers.
      send(0, 0, 8'hA5);
      wt(5);
      chk("first reply", got, 8'h00);
      send(0, 0, 8'h3C);
      wt(5);
      chk("spi reply", got, 8'h03);
      send(0, 0, 8'h96);
      wt(5);
      chk("late reply", got, 8'h03);
      chk("overrun", ovr, 1'h1);
      send(0, 0, 8'h5A);
      wt(5);
      chk("full reply", got, 8'h02);
      pop(8'hA5);
      pop(8'h3C);
      send(0, 1, 8'hA5);
      wt(6);
      for (i = 0; i < 2000 && !lnk.serial_to_device_line; i++) @(negedge mclk);
      chk("start bit", 16'(i), BAUD_DIV_RST);
      pop(8'hA5);
      @(posedge mclk);
      bl <= 1'h1;
      @(posedge mclk);
      bl <= 1'h0;
      send(1, 1, 8'hC3);
      wt(5);
      chk("dev serial", got, 8'hC3);
      send(0, 1, 8'h81);
      pop(8'h81);
      d_rst <= 1'h1;
      repeat (4) @(posedge mclk);
      d_rst <= 1'h0;
      repeat (3) @(negedge mclk);
      chk("boot app", {prog, app}, 2'h1);
      @(posedge mclk);
      d_rst <= 1'h1;
      p_rst <= 1'h1;
      repeat (4) @(posedge mclk);
      d_rst <= 1'h0;
      p_rst <= 1'h0;
      wt(0);
      for (i = 0; i < 3000 && app !== 1'h1; i++) @(negedge mclk);
      chk("timeout", i >= TO - 2 && i <= TO + 2 && !prog, 1'h1);
      tally_and_finish();
   end
endmodule
